// ===== verilog/drive_warning_monitor_defs.svh
`ifndef DRIVE_WARNING_MONITOR_DEFS_SVH
`define DRIVE_WARNING_MONITOR_DEFS_SVH
// timing
`define CLK_PERIOD_NS   4
`define SAMPLE_NS       250000
`define MIN_HOLD_NS     200000000
`define TEACH_NS        200000000
// register word indices (byte address = index * 4)
`define IDX_CTRL        4'h0
`define IDX_TH_STAGE    4'h1
`define IDX_TH_DCLINK   4'h2
`define IDX_TH_MOTOR    4'h3
`define IDX_TH_MISC     4'h4
`define IDX_TH_CURRENT  4'h5
`define IDX_TIMING      4'h6
`define IDX_REF_WIN     4'h7
`define IDX_NOLOAD      4'h8
`define IDX_STATUS      4'h9
`define IDX_ROUTE       4'hA
// control fields
`define CTRL_TEMP_EN    0
`define CTRL_CMODE_LSB  1
`define CTRL_CSRC       3
`define CTRL_OCMODE_LSB 4
`define CTRL_ERR_CLR    6
`define TIMING_FILT_LSB 16
// reset values
`define CTRL_RST        32'h0000_0000
`define TH_RST          32'hFFFF_FFFF
`define TH_DCLINK_RST   32'h0000_FFFF
`define TIMING_RST      32'h0000_0000
`define REF_WIN_RST     32'h0000_0000
`define NOLOAD_RST      16'h0000
`define ROUTE_RST       4'h0
`endif

// ===== verilog/drive_warning_pkg.sv
package drive_warning_pkg;
	typedef enum logic [1:0] {CM_ABS = 2'b00, CM_NOLOAD = 2'b01, CM_RISE = 2'b10, CM_DROP = 2'b11} cmode_t;
	typedef enum logic [1:0] {OC_OFF = 2'b00, OC_THRESH = 2'b01, OC_SHUT = 2'b10, OC_RSVD = 2'b11} ocmode_t;
	typedef enum logic [1:0] {ST_RUN = 2'b00, ST_STOP = 2'b01, ST_FAULT = 2'b10} stop_state_t;
	typedef struct packed {
		logic [15:0] stage_load;
		logic [15:0] stage_temp;
		logic [15:0] dc_volt;
		logic [15:0] motor_load;
		logic [15:0] motor_temp;
		logic [15:0] ambient_temp;
		logic [15:0] ballast_load;
		logic [15:0] motor_current;
		logic [15:0] analog_thresh;
		logic [15:0] speed_err;
	} meas_t;
	typedef struct packed {
		logic overcurrent_warn;
		logic current_warn;
		logic ballast_load_warn;
		logic ambient_temp_warn;
		logic motor_temp_warn;
		logic motor_load_warn;
		logic dc_link_under_volt_warn;
		logic dc_link_over_volt_warn;
		logic stage_temp_warn;
		logic stage_load_warn;
	} warns_t;
endpackage

// ===== verilog/drive_warning_monitor.sv
// Behaviour
// RULE1: stage load at or above threshold warns
// RULE2: stage temperature at or above threshold warns
// RULE3: dc link at or above overvoltage warns
// RULE4: dc link at or below undervoltage warns
// RULE5: motor thermal load reaching threshold warns
// RULE6: motor temperature warns only when sensor enabled
// RULE7: ambient temperature at or above threshold warns
// RULE8: ballast load at or above threshold warns
// RULE9: current sampled once per fixed sample period
// RULE10: current monitor disabled until reference reached
// RULE11: absolute mode warns when filtered current exceeds
// RULE12: current warnings held at least minimum time
// RULE13: warn only after condition persists window time
// RULE14: first order lowpass on monitored current
// RULE15: threshold from register or analog input
// RULE16: teach held long enough stores no-load current
// RULE17: rise mode warns on slope above threshold
// RULE18: drop mode warns on slope below threshold
// RULE19: over-current off mode never warns
// RULE20: over-current threshold mode warns when reference reached
// RULE21: shutdown disables controller, quick stop, then error
// RULE22: current warnings routable to digital outputs
// RULE23: reference reached after speed stays in window
// RULE24: compare on sample tick, clear after hold
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "drive_warning_monitor_defs.svh"
module drive_warning_monitor #(
	parameter int unsigned SAMPLE_CYC = `SAMPLE_NS / `CLK_PERIOD_NS,
	parameter int unsigned HOLD_SMP   = `MIN_HOLD_NS / `SAMPLE_NS,
	parameter int unsigned TEACH_SMP  = `TEACH_NS / `SAMPLE_NS
) (
	input  wire logic                  core_clk,
	input  wire logic                  rst_n,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  drive_warning_pkg::meas_t   meas,
	input  wire logic                  teach_pin,
	input  wire logic                  stop_done,
	output drive_warning_pkg::warns_t  warn,
	output logic [1:0]                 dig_out,
	output logic                       ref_value_reached_msg,
	output logic                       ctrl_enable,
	output logic                       quick_stop,
	output logic                       warning_caused_error
);
	localparam logic [31:0] CFG_RST [0:7] = '{`CTRL_RST, `TH_RST, `TH_DCLINK_RST, `TH_RST,
		`TH_RST, `TH_RST, `TIMING_RST, `REF_WIN_RST};

	logic [31:0]                    cfg_r [0:7];
	logic [15:0]                    noload_r;
	logic [3:0]                     route_r;
	logic [31:0]                    prdata_r;
	logic [31:0]                    tick_cnt_r;
	logic                           tick;
	drive_warning_pkg::warns_t      warn_r;
	logic                           teach_s1_r;
	logic                           teach_s2_r;
	logic [31:0]                    teach_cnt_r;
	logic                           teach_load;
	logic [15:0]                    filt_r;
	logic [15:0]                    prev_cur_r;
	logic [15:0]                    ref_cnt_r;
	logic                           ref_r;
	drive_warning_pkg::stop_state_t st_r;
	drive_warning_pkg::stop_state_t st_nxt;
	logic                           ctrl_enable_r;
	logic                           quick_stop_r;
	logic                           error_r;
	logic [3:0]                     idx;
	logic                           mapped;
	logic                           wr;
	logic                           err_clr;
	logic                           temp_en;
	logic                           csrc;
	drive_warning_pkg::cmode_t      cmode;
	drive_warning_pkg::ocmode_t     ocmode;
	logic [15:0]                    cur_th;
	logic [3:0]                     filt_k;
	logic signed [16:0]             fdiff;
	logic signed [16:0]             fstep;
	logic signed [16:0]             delta;
	logic signed [18:0]             rate;
	logic signed [18:0]             th_s;
	logic [1:0]                     cond;
	logic [1:0]                     on;
	logic [1:0]                     cw;
	logic [15:0]                    win [0:1];
	logic [7:0]                     cmp;

	// apb decode; zero wait states, unmapped words answer with pslverr
	assign idx     = paddr[5:2];
	assign mapped  = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0) && (idx <= `IDX_ROUTE);
	assign wr      = psel & penable & pwrite & mapped;
	assign err_clr = wr && (idx == `IDX_CTRL) && pwdata[`CTRL_ERR_CLR];
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata  = prdata_r;

	// configuration words, one flop bank per index
	genvar k;
	generate
		for (k = 0; k < 8; k++) begin : g_cfg
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					cfg_r[k] <= CFG_RST[k];
				end else if (wr && idx == 4'(k)) begin
					cfg_r[k] <= pwdata;
				end
			end
		end
	endgenerate

	// output routing select
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			route_r <= `ROUTE_RST;
		end else if (wr && idx == `IDX_ROUTE) begin
			route_r <= pwdata[3:0];
		end
	end

	// read data captured in the setup phase so it is stable in access
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_r <= 32'h0000_0000;
		end else if (psel && !penable) begin
			case (idx)
				`IDX_NOLOAD: prdata_r <= {16'h0000, noload_r};
				`IDX_STATUS: prdata_r <= {19'h00000, ref_r, st_r, warn_r};
				`IDX_ROUTE:  prdata_r <= {28'h0000000, route_r};
				default:     prdata_r <= (idx < `IDX_NOLOAD) ? cfg_r[idx[2:0]] : 32'h0000_0000;
			endcase
		end
	end

	// field views
	assign temp_en = cfg_r[0][`CTRL_TEMP_EN];
	assign csrc    = cfg_r[0][`CTRL_CSRC];
	assign cmode   = drive_warning_pkg::cmode_t'(cfg_r[0][`CTRL_CMODE_LSB +: 2]);
	assign ocmode  = drive_warning_pkg::ocmode_t'(cfg_r[0][`CTRL_OCMODE_LSB +: 2]);
	assign filt_k  = cfg_r[6][`TIMING_FILT_LSB +: 4];
	assign cur_th  = csrc ? meas.analog_thresh : cfg_r[5][15:0]; // see RULE15

	// sample period strobe
	assign tick = (tick_cnt_r == SAMPLE_CYC - 1); // see RULE9
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_r <= 32'h0000_0000;
		end else begin
			tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
		end
	end

	// plain threshold comparisons
	assign cmp[0] = meas.stage_load >= cfg_r[1][15:0]; // see RULE1
	assign cmp[1] = meas.stage_temp >= cfg_r[1][31:16]; // see RULE2
	assign cmp[2] = meas.dc_volt >= cfg_r[2][15:0]; // see RULE3
	assign cmp[3] = meas.dc_volt <= cfg_r[2][31:16]; // see RULE4
	assign cmp[4] = meas.motor_load >= cfg_r[3][15:0]; // see RULE5
	assign cmp[5] = temp_en && (meas.motor_temp >= cfg_r[3][31:16]); // see RULE6
	assign cmp[6] = meas.ambient_temp >= cfg_r[4][15:0]; // see RULE7
	assign cmp[7] = meas.ballast_load >= cfg_r[4][31:16]; // see RULE8

	// plain warnings update only on the tick and follow the condition; current warnings copy their engine flags every cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			warn_r <= '0;
		end else begin
			if (tick) begin
				warn_r[7:0] <= cmp; // see RULE24
			end
			warn_r.current_warn     <= cw[0];
			warn_r.overcurrent_warn <= cw[1];
		end
	end
	assign warn = warn_r;

	// teach input from a pin, two-flop synchroniser
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			teach_s1_r <= 1'b0;
			teach_s2_r <= 1'b0;
		end else begin
			teach_s1_r <= teach_pin;
			teach_s2_r <= teach_s1_r;
		end
	end

	// teach hold counter; loads once per press
	assign teach_load = tick && teach_s2_r && (teach_cnt_r == TEACH_SMP - 1);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			teach_cnt_r <= 32'h0000_0000;
		end else if (tick) begin
			if (!teach_s2_r) begin
				teach_cnt_r <= 32'h0000_0000;
			end else if (teach_cnt_r < TEACH_SMP) begin
				teach_cnt_r <= teach_cnt_r + 32'h0000_0001;
			end
		end
	end

	// teach overrides a software write in the same cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			noload_r <= `NOLOAD_RST;
		end else if (teach_load) begin
			noload_r <= meas.motor_current; // see RULE16
		end else if (wr && idx == `IDX_NOLOAD) begin
			noload_r <= pwdata[15:0];
		end
	end

	// lowpass: time constant is 2^k samples, k=0 passes straight through
	assign fdiff = $signed({1'b0, meas.motor_current}) - $signed({1'b0, filt_r});
	assign fstep = fdiff >>> filt_k;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			filt_r     <= 16'h0000;
			prev_cur_r <= 16'h0000;
		end else if (tick) begin
			filt_r     <= filt_r + fstep[15:0]; // see RULE14
			prev_cur_r <= meas.motor_current;
		end
	end

	// slope per ms: one sample is a quarter millisecond
	assign delta = $signed({1'b0, meas.motor_current}) - $signed({1'b0, prev_cur_r});
	assign rate  = {delta, 2'b00};
	assign th_s  = $signed({3'b000, cur_th});

	// reference reached window
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_cnt_r <= 16'h0000;
			ref_r     <= 1'b0;
		end else if (tick) begin
			if (meas.speed_err > cfg_r[7][15:0]) begin
				ref_cnt_r <= 16'h0000;
				ref_r     <= 1'b0;
			end else if (ref_cnt_r >= cfg_r[7][31:16]) begin
				ref_r <= 1'b1; // see RULE23
			end else begin
				ref_cnt_r <= ref_cnt_r + 16'h0001;
			end
		end
	end
	assign ref_value_reached_msg = ref_r;

	// trigger conditions of both current monitors
	always_comb begin
		case (cmode)
			drive_warning_pkg::CM_ABS:    cond[0] = filt_r > cur_th; // see RULE11
			drive_warning_pkg::CM_NOLOAD: cond[0] = {1'b0, filt_r} > ({1'b0, noload_r} + {1'b0, cur_th});
			drive_warning_pkg::CM_RISE:   cond[0] = rate > th_s; // see RULE17
			drive_warning_pkg::CM_DROP:   cond[0] = rate < -th_s; // see RULE18
			default:                      cond[0] = 1'b0;
		endcase
		cond[0] = cond[0] && ref_r; // see RULE10
		cond[1] = ref_r && (filt_r > cfg_r[5][31:16]); // see RULE20
	end
	assign on[0]  = 1'b1;
	assign on[1]  = (ocmode == drive_warning_pkg::OC_THRESH) || (ocmode == drive_warning_pkg::OC_SHUT); // see RULE19
	assign win[0] = cfg_r[6][15:0];
	assign win[1] = 16'h0000;

	// window and minimum hold, one engine per current monitor
	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_cur
			logic [15:0] win_cnt_r;
			logic [31:0] hold_cnt_r;
			logic        flag_r;
			logic        fire;
			assign fire  = cond[i] && (win_cnt_r >= win[i]); // see RULE13
			assign cw[i] = flag_r;
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					win_cnt_r  <= 16'h0000;
					hold_cnt_r <= 32'h0000_0000;
					flag_r     <= 1'b0;
				end else if (!on[i]) begin
					win_cnt_r  <= 16'h0000;
					hold_cnt_r <= 32'h0000_0000;
					flag_r     <= 1'b0;
				end else if (tick) begin
					win_cnt_r <= !cond[i] ? 16'h0000 : (fire ? win_cnt_r : win_cnt_r + 16'h0001);
					if (fire) begin
						flag_r     <= 1'b1;
						hold_cnt_r <= HOLD_SMP; // see RULE12
					end else if (hold_cnt_r != 32'h0000_0000) begin
						hold_cnt_r <= hold_cnt_r - 32'h0000_0001;
					end else begin
						flag_r <= 1'b0; // see RULE24
					end
				end
			end
			hold_min_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE12
				$fell(flag_r) && $past(on[i]) |-> $past(hold_cnt_r) == 32'h0000_0000)
				else $error("current warning dropped before hold ended");
			window_wait_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE13
				$rose(flag_r) |-> $past(cond[i]) && $past(win_cnt_r) >= $past(win[i]))
				else $error("current warning raised before window time");
		end
	endgenerate

	// digital output routing of the current warnings
	genvar j;
	generate
		for (j = 0; j < 2; j++) begin : g_out
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					dig_out[j] <= 1'b0;
				end else begin
					case (route_r[2*j +: 2])
						2'h1:    dig_out[j] <= cw[0]; // see RULE22
						2'h2:    dig_out[j] <= cw[1];
						default: dig_out[j] <= 1'b0;
					endcase
				end
			end
		end
	endgenerate

	// shutdown sequence; error stays until software clears it
	always_comb begin
		case (st_r)
			drive_warning_pkg::ST_RUN:   st_nxt = (ocmode == drive_warning_pkg::OC_SHUT && cw[1]) ?
				drive_warning_pkg::ST_STOP : drive_warning_pkg::ST_RUN; // see RULE21
			drive_warning_pkg::ST_STOP:  st_nxt = stop_done ? drive_warning_pkg::ST_FAULT : drive_warning_pkg::ST_STOP;
			drive_warning_pkg::ST_FAULT: st_nxt = err_clr ? drive_warning_pkg::ST_RUN : drive_warning_pkg::ST_FAULT;
			default:                     st_nxt = drive_warning_pkg::ST_RUN;
		endcase
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r          <= drive_warning_pkg::ST_RUN;
			ctrl_enable_r <= 1'b1;
			quick_stop_r  <= 1'b0;
			error_r       <= 1'b0;
		end else begin
			st_r          <= st_nxt;
			ctrl_enable_r <= st_nxt == drive_warning_pkg::ST_RUN;
			quick_stop_r  <= st_nxt == drive_warning_pkg::ST_STOP;
			error_r       <= st_nxt == drive_warning_pkg::ST_FAULT;
		end
	end
	assign ctrl_enable          = ctrl_enable_r;
	assign quick_stop           = quick_stop_r;
	assign warning_caused_error = error_r;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	stage_load_a: assert property (tick && meas.stage_load >= cfg_r[1][15:0] |=> warn.stage_load_warn) // see RULE1
		else $error("stage load warning missing");
	under_volt_a: assert property (tick && meas.dc_volt > cfg_r[2][31:16] |=> !warn.dc_link_under_volt_warn) // see RULE4
		else $error("undervoltage warning without cause");
	motor_temp_a: assert property (tick && !temp_en |=> !warn.motor_temp_warn) // see RULE6
		else $error("motor temperature warned while disabled");
	cur_gate_a: assert property ($rose(g_cur[0].flag_r) |-> $past(ref_r)) // see RULE10
		else $error("current warning before reference reached");
	oc_off_a: assert property (ocmode == drive_warning_pkg::OC_OFF |=> !g_cur[1].flag_r ##1 !warn.overcurrent_warn) // see RULE19
		else $error("over-current warned while off");
	shut_seq_a: assert property (st_r == drive_warning_pkg::ST_RUN && st_nxt == drive_warning_pkg::ST_STOP
		|=> !ctrl_enable && quick_stop && !warning_caused_error) // see RULE21
		else $error("shutdown did not stop the controller");
	teach_a: assert property (teach_load |=> noload_r == $past(meas.motor_current)) // see RULE16
		else $error("teach did not store the current");
	ref_drop_a: assert property (tick && meas.speed_err > cfg_r[7][15:0] |=> !ref_value_reached_msg) // see RULE23
		else $error("reference reached outside window");
	tick_space_a: assert property ($rose(tick) |=> !tick) // see RULE9
		else $error("sample strobe too frequent");

	cur_warn_c: cover property ($rose(warn.current_warn));
	oc_warn_c: cover property ($rose(warn.overcurrent_warn));
	fault_c: cover property (st_r == drive_warning_pkg::ST_FAULT ##1 st_r == drive_warning_pkg::ST_RUN);
	teach_c: cover property (teach_load);
endmodule // drive_warning_monitor

// ===== dv/drive_far_side.sv
`timescale 1ns/1ns
// stand-in for the sensing front end and the motion controller
module drive_far_side #(
	parameter int unsigned STOP_DLY = 20
) (
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	input  drive_warning_pkg::meas_t  meas_cmd,
	input  wire logic                 quick_stop,
	output drive_warning_pkg::meas_t  meas,
	output logic                      stop_done
);
	int unsigned                      ramp_cnt;

	// sensors report one cycle late, like a conversion pipe
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meas <= '0;
		end else begin
			meas <= meas_cmd;
		end
	end

	// the quick stop ramp takes time; done is only shown while a stop is asked for
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ramp_cnt  <= 0;
			stop_done <= 1'b0;
		end else if (!quick_stop) begin
			ramp_cnt  <= 0;
			stop_done <= 1'b0;
		end else if (ramp_cnt < STOP_DLY) begin
			ramp_cnt  <= ramp_cnt + 1;
		end else begin
			stop_done <= 1'b1;
		end
	end
endmodule // drive_far_side

// ===== dv/drive_warning_monitor_test.sv
`timescale 1ns/1ns
`include "drive_warning_monitor_defs.svh"
`define CHK(what, exp, got) \
	n_tests++; \
	if ((got) !== (exp)) begin \
		num_errors++; \
		$display("MISMATCH %s exp %0h got %0h", what, exp, got); \
	end
module drive_warning_monitor_test;
	localparam int unsigned SMP   = 8;
	localparam int unsigned HOLD  = 4;
	localparam int unsigned TEACH = 3;
	logic                      core_clk;
	logic                      rst_n;
	logic                      psel;
	logic                      penable;
	logic                      pwrite;
	logic [7:0]                paddr;
	logic [31:0]               pwdata;
	logic [31:0]               prdata;
	logic                      pready;
	logic                      pslverr;
	logic                      teach_pin;
	logic                      stop_done;
	logic                      quick_stop;
	logic                      ctrl_enable;
	logic                      fault;
	logic                      ref_ok;
	logic [1:0]                dig_out;
	drive_warning_pkg::meas_t  m_cmd;
	drive_warning_pkg::meas_t  meas;
	drive_warning_pkg::warns_t warn;
	int                        num_errors;
	int                        n_tests;

	drive_warning_monitor #(.SAMPLE_CYC(SMP), .HOLD_SMP(HOLD), .TEACH_SMP(TEACH)) drive_warning_monitor_i (
		.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.meas(meas), .teach_pin(teach_pin), .stop_done(stop_done), .warn(warn), .dig_out(dig_out),
		.ref_value_reached_msg(ref_ok), .ctrl_enable(ctrl_enable), .quick_stop(quick_stop),
		.warning_caused_error(fault));
	drive_far_side #(.STOP_DLY(20)) drive_far_side_i (
		.core_clk(core_clk), .rst_n(rst_n), .meas_cmd(m_cmd), .quick_stop(quick_stop),
		.meas(meas), .stop_done(stop_done));

	// clock
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	task automatic complete_run();
		if (num_errors == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// one apb transfer; answer taken at the edge that samples pready high
	task automatic apb(input logic wr, input logic [3:0] idx, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {2'b00, idx, 2'b00};
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// no wait count assumed; only the hang guard ends a stuck access
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] idx, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, idx, d, r, e);
	endtask

	task automatic rd_chk(input logic [3:0] idx, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, idx, 32'h0000_0000, r, e);
		`CHK("reg read", {1'b0, exp}, {e, r})
	endtask

	// whole sample periods, then settle to the falling edge for checks
	task automatic wait_smp(input int unsigned n);
		repeat (n * SMP) @(posedge core_clk);
		@(negedge core_clk);
	endtask

	task automatic reset_values();
		logic [31:0] r;
		logic        e;
		rd_chk(`IDX_CTRL, `CTRL_RST);
		rd_chk(`IDX_TH_STAGE, `TH_RST);
		rd_chk(`IDX_TH_DCLINK, `TH_DCLINK_RST);
		rd_chk(`IDX_NOLOAD, 32'h0000_0000);
		apb(1'b0, 4'hB, 32'h0000_0000, r, e);
		`CHK("unmapped", 33'h1_0000_0000, {e, r})
		wr(`IDX_STATUS, 32'hFFFF_FFFF);
		wait_smp(1);
		rd_chk(`IDX_STATUS, 32'h0000_1008);
	endtask

	// equal to threshold warns, one step short does not
	task automatic plain_warns();
		wr(`IDX_TH_STAGE, 32'h0050_0040);
		wr(`IDX_TH_DCLINK, 32'h00C8_0064);
		wr(`IDX_TH_MOTOR, 32'h0030_0020);
		wr(`IDX_TH_MISC, 32'h0060_0045);
		@(posedge core_clk);
		m_cmd <= {16'h0040, 16'h004F, 16'h00C8, 16'h0020, 16'h0030, 16'h0045, 16'h005F, 32'h0000_0000, 16'h000A};
		wait_smp(2);
		`CHK("plain a", 8'h5D, warn[7:0])
		wr(`IDX_CTRL, 32'h0000_0001);
		m_cmd.stage_temp   <= 16'h0050;
		m_cmd.ballast_load <= 16'h0060;
		m_cmd.dc_volt      <= 16'h00C9;
		wait_smp(2);
		`CHK("plain b", 8'hF7, warn[7:0])
		@(posedge core_clk);
		m_cmd.stage_load <= 16'h003F;
		wait_smp(2);
		`CHK("plain c", 8'hF6, warn[7:0])
	endtask

	task automatic current_abs();
		wr(`IDX_REF_WIN, 32'h0002_0005);
		wr(`IDX_TH_CURRENT, 32'hFFFF_012C);
		wr(`IDX_TIMING, 32'h0002_0000);
		wr(`IDX_ROUTE, 32'h0000_0009);
		wr(`IDX_CTRL, 32'h0000_0000);
		m_cmd.motor_current <= 16'h0190;
		wait_smp(12);
		`CHK("gated", 1'b0, warn.current_warn)
		`CHK("ref low", 1'b0, ref_ok)
		@(posedge core_clk);
		m_cmd.motor_current <= 16'h0000;
		m_cmd.speed_err     <= 16'h0003;
		wait_smp(12);
		`CHK("ref high", 1'b1, ref_ok)
		@(posedge core_clk);
		m_cmd.motor_current <= 16'h0190;
		wait_smp(1);
		`CHK("filtered", 1'b0, warn.current_warn)
		wait_smp(10);
		`CHK("abs", 1'b1, warn.current_warn)
		`CHK("route", 2'b01, dig_out)
		@(posedge core_clk);
		m_cmd.motor_current <= 16'h0000;
		wait_smp(1);
		`CHK("hold", 1'b1, warn.current_warn)
		wait_smp(HOLD + 4);
		`CHK("clear", 1'b0, warn.current_warn)
		// analog source: higher analog limit must mask the register limit
		wr(`IDX_CTRL, 32'h0000_0008);
		m_cmd.analog_thresh <= 16'h01F4;
		m_cmd.motor_current <= 16'h0190;
		wait_smp(10);
		`CHK("analog hi", 1'b0, warn.current_warn)
		@(posedge core_clk);
		m_cmd.analog_thresh <= 16'h015E;
		wait_smp(10);
		`CHK("analog lo", 1'b1, warn.current_warn)
	endtask

	// slope modes: 4 x step against the limit, boundary step first
	task automatic current_slope();
		wr(`IDX_CTRL, 32'h0000_0004);
		wr(`IDX_TH_CURRENT, 32'hFFFF_0190);
		m_cmd.motor_current <= 16'h0064;
		wait_smp(HOLD + 4);
		`CHK("rise idle", 1'b0, warn.current_warn)
		@(posedge core_clk);
		m_cmd.motor_current <= 16'h00C8;
		wait_smp(2);
		`CHK("rise edge", 1'b0, warn.current_warn)
		@(posedge core_clk);
		m_cmd.motor_current <= 16'h012D;
		wait_smp(2);
		`CHK("rise", 1'b1, warn.current_warn)
		wr(`IDX_CTRL, 32'h0000_0006);
		wait_smp(HOLD + 4);
		`CHK("drop idle", 1'b0, warn.current_warn)
		@(posedge core_clk);
		m_cmd.motor_current <= 16'h00C8;
		wait_smp(2);
		`CHK("drop", 1'b1, warn.current_warn)
	endtask

	task automatic overcurrent();
		wr(`IDX_CTRL, 32'h0000_0000);
		wr(`IDX_TH_CURRENT, 32'h0100_FFFF);
		m_cmd.motor_current <= 16'h0200;
		wait_smp(10);
		`CHK("oc off", 1'b0, warn.overcurrent_warn)
		wr(`IDX_CTRL, 32'h0000_0010);
		wait_smp(10);
		`CHK("oc on", 2'b11, {warn.overcurrent_warn, ctrl_enable})
		`CHK("oc route", 1'b1, dig_out[1])
		wr(`IDX_CTRL, 32'h0000_0020);
		wait_smp(1);
		`CHK("stopping", 3'b010, {ctrl_enable, quick_stop, fault})
		wait_smp(5);
		`CHK("faulted", 3'b001, {ctrl_enable, quick_stop, fault})
		@(posedge core_clk);
		m_cmd.motor_current <= 16'h0000;
		wr(`IDX_CTRL, 32'h0000_0040);
		wait_smp(1);
		`CHK("fault clr", 3'b100, {ctrl_enable, quick_stop, fault})
		wr(`IDX_CTRL, 32'h0000_0000);
	endtask

	// a short press must not teach, a long one must
	task automatic teach();
		wr(`IDX_CTRL, 32'h0000_0002);
		wr(`IDX_NOLOAD, 32'h0000_0007);
		m_cmd.motor_current <= 16'h0050;
		teach_pin           <= 1'b1;
		wait_smp(1);
		@(posedge core_clk);
		teach_pin <= 1'b0;
		wait_smp(2);
		rd_chk(`IDX_NOLOAD, 32'h0000_0007);
		teach_pin <= 1'b1;
		wait_smp(TEACH + 3);
		@(posedge core_clk);
		teach_pin <= 1'b0;
		wait_smp(1);
		rd_chk(`IDX_NOLOAD, 32'h0000_0050);
		// limit rides on the taught current; a four-sample window delays the warning
		wr(`IDX_TH_CURRENT, 32'hFFFF_0020);
		wr(`IDX_TIMING, 32'h0002_0004);
		wait_smp(4);
		`CHK("noload base", 1'b0, warn.current_warn)
		@(posedge core_clk);
		m_cmd.motor_current <= 16'h0100;
		wait_smp(3);
		`CHK("window wait", 1'b0, warn.current_warn)
		wait_smp(7);
		`CHK("noload", 1'b1, warn.current_warn)
	endtask

	initial begin
		num_errors = 0;
		n_tests    = 0;
		rst_n      = 1'b0;
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = 8'h00;
		pwdata     = 32'h0000_0000;
		teach_pin  = 1'b0;
		m_cmd      = '0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		reset_values();
		plain_warns();
		current_abs();
		current_slope();
		overcurrent();
		teach();
		complete_run();
	end

	// hang guard at 10000 cycles, far beyond the roughly 1300 cycles the run needs
	initial begin
		#40000;
		num_errors++;
		complete_run();
	end
endmodule // drive_warning_monitor_test
